// ### common/proc_reg_pkg.sv
package proc_reg_pkg;

  typedef enum logic [1:0] {ACC_RW, ACC_RO, ACC_WO} access_e;

  typedef struct packed {
    logic [7:0]  num;
    access_e     acc;
    logic        io;
    logic [3:0]  pp;    // context word index, f when not per-process
    logic [31:0] rst;
  } reg_entry_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        kernel;
    logic        is_io;
    logic [31:0] addr;
    logic [31:0] wdata;
  } req_s;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [31:0] rdata;
  } rsp_s;

  typedef struct packed {
    logic             load;
    logic [9:0][31:0] word;
  } ctx_s;

  typedef struct packed {
    logic [3:0]       req;
    logic [3:0][15:0] vec;
  } ext_irq_s;

  typedef struct packed {
    logic        tb_all;
    logic        tb_single;
    logic        tb_check;
    logic        io_reset;
    logic        wbuf_clear;
    logic [31:0] data;
  } effects_s;

  localparam int          NUM_SLOTS = 46;
  localparam int          SLOT_W    = 6;
  localparam logic [3:0]  PP_NONE   = 4'hf;
  localparam logic [31:0] IO_BASE   = 32'he1000000;
  localparam logic [15:0] VEC_TIMER = 16'h00c0;
  localparam int          TIMER_LVL = 2;   // level 16 is bit 2 of 14..17
  localparam int          CLK_NS    = 10;
  localparam int          US_NS     = 1000;
  localparam int          US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TICK_US   = 10000;
  localparam int          TICK_CYC  = TICK_US * 1000 / CLK_NS;
  localparam int          ECR_TIMER = 0;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_RUN = 0;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_XFR = 4;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_SGL = 5;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_IE  = 6;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_INT = 7;
  localparam int INTERVAL_CLOCK_CONTROL_STATUS_ERR = 31;

  localparam logic [SLOT_W-1:0] SLOT_PROCESSOR_IDENTIFICATION = 6'h0b;
  localparam logic [SLOT_W-1:0] SLOT_IPL   = 6'h0e;
  localparam logic [SLOT_W-1:0] SLOT_SOFT_INTERRUPT_REQUEST  = 6'h10;
  localparam logic [SLOT_W-1:0] SLOT_SOFT_INTERRUPT_SUMMARY  = 6'h11;
  localparam logic [SLOT_W-1:0] SLOT_INTERVAL_CLOCK_CONTROL_STATUS  = 6'h12;
  localparam logic [SLOT_W-1:0] SLOT_NEXT_INTERVAL_COUNT  = 6'h13;
  localparam logic [SLOT_W-1:0] SLOT_ICR   = 6'h14;
  localparam logic [SLOT_W-1:0] SLOT_IORST = 6'h21;
  localparam logic [SLOT_W-1:0] SLOT_MEMORY_MAPPING_ENABLE = 6'h22;
  localparam logic [SLOT_W-1:0] SLOT_TRANSLATION_INVALIDATE_ALL  = 6'h23;
  localparam logic [SLOT_W-1:0] SLOT_TRANSLATION_INVALIDATE_SINGLE  = 6'h24;
  localparam logic [SLOT_W-1:0] SLOT_SID   = 6'h26;
  localparam logic [SLOT_W-1:0] SLOT_TRANSLATION_CHECK = 6'h27;
  localparam logic [SLOT_W-1:0] SLOT_LEVEL14_INTERRUPT_ACK = 6'h28;
  localparam logic [SLOT_W-1:0] SLOT_LEVEL17_INTERRUPT_ACK = 6'h2b;
  localparam logic [SLOT_W-1:0] SLOT_CWB   = 6'h2c;
  localparam logic [SLOT_W-1:0] SLOT_ECR   = 6'h2d;

  // number, access, io reachable, context word, value after reset
  localparam reg_entry_s REG_TABLE [NUM_SLOTS] = '{
    '{8'h00, ACC_RW, 1'b0, 4'h0, 32'h0}, '{8'h01, ACC_RW, 1'b0, 4'h1, 32'h0},
    '{8'h02, ACC_RW, 1'b0, 4'h2, 32'h0}, '{8'h03, ACC_RW, 1'b0, 4'h3, 32'h0},
    '{8'h04, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h08, ACC_RW, 1'b0, 4'h4, 32'h0}, '{8'h09, ACC_RW, 1'b0, 4'h5, 32'h0},
    '{8'h0a, ACC_RW, 1'b0, 4'h6, 32'h0}, '{8'h0b, ACC_RW, 1'b0, 4'h7, 32'h0},
    '{8'h0c, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h0d, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h0e, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h10, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h11, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h12, ACC_RW, 1'b0, PP_NONE, 32'h1f},
    '{8'h13, ACC_RW, 1'b0, 4'h8, 32'h4},
    '{8'h14, ACC_WO, 1'b0, PP_NONE, 32'h0},
    '{8'h15, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h18, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h19, ACC_WO, 1'b1, PP_NONE, 32'h0},
    '{8'h1a, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h1b, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h1c, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h1d, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h1e, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h1f, ACC_WO, 1'b1, PP_NONE, 32'h0},
    '{8'h20, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h21, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h22, ACC_RW, 1'b1, PP_NONE, 32'h80},
    '{8'h23, ACC_WO, 1'b1, PP_NONE, 32'h0},
    '{8'h26, ACC_WO, 1'b0, PP_NONE, 32'h0},
    '{8'h2a, ACC_RO, 1'b0, PP_NONE, 32'h0},
    '{8'h2b, ACC_RO, 1'b0, PP_NONE, 32'h0},
    '{8'h37, ACC_WO, 1'b1, PP_NONE, 32'h0},
    '{8'h38, ACC_RW, 1'b0, PP_NONE, 32'h0},
    '{8'h39, ACC_WO, 1'b0, PP_NONE, 32'h0},
    '{8'h3a, ACC_WO, 1'b0, PP_NONE, 32'h0},
    '{8'h3d, ACC_RW, 1'b0, 4'h9, 32'h0},
    '{8'h3e, ACC_RO, 1'b0, PP_NONE, 32'h0},
    '{8'h3f, ACC_WO, 1'b0, PP_NONE, 32'h0},
    '{8'h40, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h41, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h42, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h43, ACC_RO, 1'b1, PP_NONE, 32'h0},
    '{8'h44, ACC_RW, 1'b1, PP_NONE, 32'h0},
    '{8'h7d, ACC_RW, 1'b0, PP_NONE, 32'h0}
  };

endpackage

// ### src/processor_register_bank.sv
`timescale 1ns/100ps
`default_nettype none

module processor_register_bank
  import proc_reg_pkg::*;
#(
  parameter int          TICK_CYCLES = TICK_CYC,
  parameter logic [31:0] SYS_ID      = 32'h5a000001  // arbitrary value
) (
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  input  wire req_s     req,
  input  wire ctx_s     ctx,
  input  wire ext_irq_s ext_irq,
  output rsp_s          rsp,
  output effects_s      effects,
  output logic [3:0]    irq_req,
  output logic [4:0]    cur_ipl,
  output logic          mapping_enable
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int US_W   = $clog2(US_CYCLES + 1);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  logic [31:0]       bank_reg [NUM_SLOTS];
  logic [31:0]       interval_clock_control_status_next;
  logic [31:0]       soft_interrupt_summary_next;
  logic [31:0]       icr_next;
  logic [7:0]        num;
  logic              num_ok;
  logic              hit;
  logic [SLOT_W-1:0] slot;
  access_e           acc;
  logic              allowed;
  logic              wr;
  logic              rd;
  logic              full_timer;
  logic              timer_evt;
  logic              overflow;
  logic              icr_step;
  logic              timer_pending;
  logic [31:0]       rdata_next;
  logic [US_W-1:0]   us_cnt_reg;
  logic              us_tick;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              subset_tick;
  logic [1:0]        lvl;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // io accesses land in a 1 kB window, one word per register number
  always_comb begin
    if (req.is_io) begin
      num    = req.addr[9:2];
      num_ok = (req.addr[31:10] == IO_BASE[31:10])
               && (req.addr[1:0] == 2'b00);
    end else begin
      num    = req.addr[7:0];
      num_ok = (req.addr[31:8] == 24'h0);
    end
  end

  // table search; an io access only finds registers with an io address
  always_comb begin
    hit  = 1'b0;
    slot = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (REG_TABLE[i].num == num && (!req.is_io || REG_TABLE[i].io)) begin
        hit  = num_ok;
        slot = SLOT_W'(i);
      end
    end
  end

  assign acc = REG_TABLE[slot].acc;

  // register moves need kernel mode; memory-mapped accesses are
  // protected by the page tables and so carry no mode check here
  assign allowed = req.valid && (req.is_io || req.kernel);
  // unmapped numbers and read-only targets drop the write silently
  assign wr = allowed && req.write && hit && acc != ACC_RO;
  assign rd = allowed && !req.write && hit && acc != ACC_WO;

  assign full_timer = bank_reg[SLOT_ECR][ECR_TIMER];

  ////////////////////////////////////////////////////////////////////////
  // timebase dividers

  // microsecond enable for the full interval counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_reg <= '0;
    end else if (us_cnt_reg == US_W'(US_CYCLES - 1)) begin
      us_cnt_reg <= '0;
    end else begin
      us_cnt_reg <= us_cnt_reg + 1'b1;
    end
  end

  assign us_tick = (us_cnt_reg == US_W'(US_CYCLES - 1));

  // fixed-rate tick used when the count registers are not enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign subset_tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // interval timer

  // single step only counts while the timer is stopped
  always_comb begin
    icr_step = 1'b0;
    if (full_timer) begin
      if (bank_reg[SLOT_INTERVAL_CLOCK_CONTROL_STATUS][INTERVAL_CLOCK_CONTROL_STATUS_RUN]) begin
        icr_step = us_tick;
      end else begin
        icr_step = wr && slot == SLOT_INTERVAL_CLOCK_CONTROL_STATUS && req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_SGL];
      end
    end
  end

  assign overflow  = icr_step && (bank_reg[SLOT_ICR] == 32'hffffffff);
  assign timer_evt = full_timer ? overflow : subset_tick;

  // transfer loads the count from the next-count register
  always_comb begin
    icr_next = bank_reg[SLOT_ICR];
    if (full_timer) begin
      if (wr && slot == SLOT_INTERVAL_CLOCK_CONTROL_STATUS && req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_XFR]) begin
        icr_next = bank_reg[SLOT_NEXT_INTERVAL_COUNT];
      end else if (overflow) begin
        icr_next = bank_reg[SLOT_NEXT_INTERVAL_COUNT];
      end else if (icr_step) begin
        icr_next = bank_reg[SLOT_ICR] + 32'h1;
      end
    end
  end

  // interrupt flag clears on writing one, error flag only with the count registers enabled; a timer event in
  // the same cycle wins so that no tick is lost
  always_comb begin
    interval_clock_control_status_next = bank_reg[SLOT_INTERVAL_CLOCK_CONTROL_STATUS];
    if (wr && slot == SLOT_INTERVAL_CLOCK_CONTROL_STATUS) begin
      interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_IE] = req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_IE];
      if (req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_INT]) begin
        interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_INT] = 1'b0;
      end
      if (full_timer) begin
        interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_RUN] = req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_RUN];
        if (req.wdata[INTERVAL_CLOCK_CONTROL_STATUS_ERR]) begin
          interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_ERR] = 1'b0;
        end
      end
    end
    if (timer_evt) begin
      if (full_timer && bank_reg[SLOT_INTERVAL_CLOCK_CONTROL_STATUS][INTERVAL_CLOCK_CONTROL_STATUS_INT]) begin
        interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_ERR] = 1'b1;  // missed a tick
      end
      interval_clock_control_status_next[INTERVAL_CLOCK_CONTROL_STATUS_INT] = 1'b1;
    end
  end

  assign timer_pending = bank_reg[SLOT_INTERVAL_CLOCK_CONTROL_STATUS][INTERVAL_CLOCK_CONTROL_STATUS_INT]
                         && bank_reg[SLOT_INTERVAL_CLOCK_CONTROL_STATUS][INTERVAL_CLOCK_CONTROL_STATUS_IE];

  ////////////////////////////////////////////////////////////////////////
  // software interrupt summary

  // a request write sets one summary bit; level 0 is not a level
  always_comb begin
    soft_interrupt_summary_next = bank_reg[SLOT_SOFT_INTERRUPT_SUMMARY];
    if (wr && slot == SLOT_SOFT_INTERRUPT_SUMMARY) begin
      soft_interrupt_summary_next = {16'h0, req.wdata[15:1], 1'b0};
    end
    if (wr && slot == SLOT_SOFT_INTERRUPT_REQUEST && req.wdata[3:0] != 4'h0) begin
      soft_interrupt_summary_next[req.wdata[3:0]] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage

  // one flop word per mapped number; reset loads the initial values
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_bank
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        bank_reg[i] <= REG_TABLE[i].rst;
      end else if (i == SLOT_INTERVAL_CLOCK_CONTROL_STATUS) begin
        bank_reg[i] <= interval_clock_control_status_next;
      end else if (i == SLOT_ICR) begin
        bank_reg[i] <= icr_next;
      end else if (i == SLOT_SOFT_INTERRUPT_SUMMARY) begin
        bank_reg[i] <= soft_interrupt_summary_next;
      end else if (REG_TABLE[i].pp != PP_NONE && ctx.load) begin
        bank_reg[i] <= ctx.word[REG_TABLE[i].pp];
      end else if (wr && slot == SLOT_W'(i)) begin
        // class 3 console storage simply keeps what is written
        if (i != SLOT_NEXT_INTERVAL_COUNT || full_timer) begin
          bank_reg[i] <= req.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  assign lvl = 2'(slot - SLOT_LEVEL14_INTERRUPT_ACK);

  // acknowledge reads arbitrate; the timer yields to the external request on level 16
  always_comb begin
    rdata_next = 32'h0;  // also the answer for write-only targets
    if (rd) begin
      if (slot >= SLOT_LEVEL14_INTERRUPT_ACK && slot <= SLOT_LEVEL17_INTERRUPT_ACK) begin
        if (ext_irq.req[lvl]) begin
          rdata_next = {16'h0, ext_irq.vec[lvl]};
        end else if (lvl == 2'(TIMER_LVL) && timer_pending) begin
          rdata_next = {16'h0, VEC_TIMER};
        end
      end else if (slot == SLOT_ICR) begin
        rdata_next = full_timer ? bank_reg[SLOT_ICR] : 32'h0;
      end else if (slot == SLOT_SID) begin
        rdata_next = SYS_ID;
      end else begin
        rdata_next = bank_reg[slot];
      end
    end
  end

  // answer one cycle after every request; fault on a user-mode move
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.fault <= req.valid && !req.is_io && !req.kernel;
      rsp.rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // side effects of writes

  // one-cycle strobes to the translation buffer, io bus and write buffer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      effects <= '0;
    end else begin
      effects.tb_all     <= wr && slot == SLOT_TRANSLATION_INVALIDATE_ALL;
      effects.tb_single  <= wr && slot == SLOT_TRANSLATION_INVALIDATE_SINGLE;
      effects.tb_check   <= wr && slot == SLOT_TRANSLATION_CHECK;
      effects.io_reset   <= wr && slot == SLOT_IORST;
      effects.wbuf_clear <= wr && slot == SLOT_CWB;
      effects.data       <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt requests and status

  // levels 14..17 on bits 0..3; the timer joins level 16
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= ext_irq.req
                 | (4'(timer_pending) << TIMER_LVL);
    end
  end

  assign cur_ipl        = bank_reg[SLOT_IPL][4:0];
  assign mapping_enable = bank_reg[SLOT_MEMORY_MAPPING_ENABLE][0];

endmodule // processor_register_bank

`default_nettype wire

// ### verif/reg_bank_props.sv
`timescale 1ns/100ps
`default_nettype none
module reg_bank_props
  import proc_reg_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire req_s       req,
  input wire ctx_s       ctx,
  input wire ext_irq_s   ext_irq,
  input wire rsp_s       rsp,
  input wire effects_s   effects,
  input wire logic [3:0] irq_req,
  input wire logic [4:0] cur_ipl,
  input wire logic       mapping_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // a register move outside kernel mode, io alias excluded
  logic user_move;
  assign user_move = req.valid && !req.kernel && !req.is_io;
  ////////////////////////////////////////////////////////////////////////
  a_rsp_follows:
    assert property (req.valid |=> rsp.valid)
    else $error("no answer after a move");
  a_rsp_only_asked:
    assert property (!req.valid |=> !rsp.valid)
    else $error("answer without a move");
  a_user_fault:
    assert property (user_move |=> rsp.fault && rsp.rdata == 32'h0)
    else $error("user move not faulted");
  a_kernel_clean:
    assert property (req.valid && !user_move |=> !rsp.fault)
    else $error("kernel move faulted");
  // a prior move may still land, so only isolated user moves count
  a_user_no_effect:
    assert property (user_move && !$past(req.valid) |=>
      $stable(cur_ipl) && $stable(mapping_enable))
    else $error("user move changed state");
  a_wo_reads_zero:
    assert property (req.valid && !req.write && req.kernel && !req.is_io &&
      req.addr inside {32'h14, 32'h19, 32'h1f, 32'h23, 32'h26, 32'h37,
      32'h39, 32'h3a, 32'h3f} |=> rsp.rdata == 32'h0)
    else $error("write-only read not zero");
  a_unmapped_quiet:
    assert property (req.valid && req.kernel && !req.is_io &&
      req.addr inside {32'h5, 32'hf} |=> rsp.rdata == 32'h0 && !rsp.fault)
    else $error("unmapped access not quiet");
  a_tb_all_pulse:
    assert property (req.valid && req.write && req.kernel && !req.is_io &&
      req.addr == 32'h39 |=> effects.tb_all &&
      effects.data == $past(req.wdata))
    else $error("invalidate-all pulse missing");
  a_ipl_reset:
    assert property ($rose(rst_n) |-> cur_ipl == 5'h1f && !mapping_enable)
    else $error("reset values wrong");
  a_ctx_others:
    assert property (ctx.load && !req.valid && !$past(req.valid) |=>
      $stable(cur_ipl) && $stable(mapping_enable))
    else $error("context load touched others");
  a_irq_levels:
    assert property (1'b1 |=> irq_req[3] == $past(ext_irq.req[3]) &&
      irq_req[1:0] == $past(ext_irq.req[1:0]))
    else $error("request levels wrong");
endmodule // reg_bank_props

bind processor_register_bank reg_bank_props reg_bank_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .ctx(ctx),
  .ext_irq(ext_irq), .rsp(rsp), .effects(effects), .irq_req(irq_req),
  .cur_ipl(cur_ipl), .mapping_enable(mapping_enable));
`default_nettype wire

// ### verif/exec_unit_model.sv
`timescale 1ns/100ps
`default_nettype none
module exec_unit_model
  import proc_reg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire rsp_s rsp,
  output req_s      req
);
  initial req = '0;
  // one move: held through the taking edge, answer read after it;
  // released lines show inverted values so stale data is never trusted
  task automatic move(input logic w, k, io, input logic [31:0] a, d,
                      output logic [31:0] q, output logic f);
    @(posedge clk_sys);
    #1 req <= '{1'b1, w, k, io, a, d};
    @(posedge clk_sys);
    #1 q = rsp.rdata;
    f = rsp.valid ? rsp.fault : 1'bx;
    req <= '{1'b0, ~w, ~k, ~io, ~a, ~d};
  endtask
endmodule // exec_unit_model
`default_nettype wire

// ### verif/processor_register_bank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module processor_register_bank_tb_top;
  import proc_reg_pkg::*;
  localparam int          TICK   = 20;
  localparam logic [31:0] SYS_ID = 32'h5a5a0002;  // arbitrary value
  localparam logic [31:0] PP [10] = '{0, 1, 2, 3, 8, 9, 10, 11, 19, 61};
  logic       clk_sys = 0;
  logic       rst_n = 0;
  req_s       req;
  ctx_s       ctx = '0;
  ext_irq_s   ext_irq = '0;
  rsp_s       rsp;
  effects_s   effects;
  logic [3:0] irq_req;
  logic [4:0] cur_ipl;
  logic       mapping_enable;
  logic [31:0] q;
  logic        f;
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  processor_register_bank #(.TICK_CYCLES(TICK), .SYS_ID(SYS_ID))
    processor_register_bank_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(req), .ctx(ctx), .ext_irq(ext_irq), .rsp(rsp),
    .effects(effects), .irq_req(irq_req), .cur_ipl(cur_ipl),
    .mapping_enable(mapping_enable));
  exec_unit_model exec_unit_model_i (.clk_sys(clk_sys), .rsp(rsp),
    .req(req));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // io alias chosen by address; only user non-io moves may fault
  task automatic wr(input logic [31:0] a, d, input logic k = 1'b1);
    exec_unit_model_i.move(1'b1, k, a[31:24] == 8'he1, a, d, q, f);
    check("fault", 32'(f), 32'(!k && a[31:24] != 8'he1));
  endtask
  task automatic rd(input logic [31:0] a, exp);
    exec_unit_model_i.move(1'b0, 1'b1, a[31:24] == 8'he1, a, 0, q, f);
    check($sformatf("reg %h", a), q, exp);
    check("fault", 32'(f), 0);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // run is about 150 cycles; far more than that means a hang
  initial begin
    #50us;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1;
    rd(32'h12, 32'h1f);
    rd(32'h13, 32'h4);
    rd(32'h22, 32'h80);
    check("ipl pin", 32'(cur_ipl), 32'h1f);
    $display("test reset values done");
    wr(32'h12, 32'h10);
    rd(32'h12, 32'h10);
    check("ipl pin", 32'(cur_ipl), 32'h10);
    wr(32'h38, 32'h1);
    check("map pin", 32'(mapping_enable), 1);
    wr(32'h3e, 32'h0);
    rd(32'h3e, SYS_ID);
    wr(32'h23, 32'h41);
    rd(32'h23, 32'h0);
    wr(32'h39, 32'h5);
    check("tb all", 32'(effects.tb_all), 1);
    check("fx data", effects.data, 32'h5);
    wr(32'h3a, 32'h6);
    check("tb single", 32'(effects.tb_single), 1);
    wr(32'h3f, 32'h7);
    check("tb check", 32'(effects.tb_check), 1);
    wr(32'he10000dc, 32'h1);
    check("io reset", 32'(effects.io_reset), 1);
    wr(32'h44, 32'h0);
    check("wbuf clear", 32'(effects.wbuf_clear), 1);
    wr(32'h14, 32'h3);
    rd(32'h15, 32'h8);
    wr(32'h12, 32'h3, 1'b0);
    rd(32'h12, 32'h10);
    wr(32'h5, 32'h77);
    rd(32'h5, 32'h0);
    wr(32'h1c, 32'h1);
    $display("test access kinds done");
    // count registers stay dead until the enable bit is set
    wr(32'he1000064, 32'hfffffff0);
    wr(32'he1000060, 32'h10);
    rd(32'he1000068, 32'h0);
    wr(32'h7d, 32'h1);
    wr(32'he1000064, 32'hfffffff0);
    wr(32'he1000060, 32'h10);
    rd(32'he1000068, 32'hfffffff0);
    rd(32'h1a, 32'hfffffff0);
    // single step while stopped advances the count by one
    wr(32'he1000060, 32'h20);
    rd(32'h1a, 32'hfffffff1);
    wr(32'h7d, 32'h0);
    $display("test interval count done");
    wr(32'he1000060, 32'h40);
    repeat (TICK + 2) @(posedge clk_sys);
    #1 check("timer irq", 32'(irq_req[2]), 1);
    rd(32'h42, 32'hc0);
    ext_irq.vec[2] = 16'h1234;
    ext_irq.req[2] = 1'b1;
    rd(32'h42, 32'h1234);
    ext_irq = '0;
    wr(32'he1000060, 32'h80);
    repeat (2) @(posedge clk_sys);
    #1 check("timer irq", 32'(irq_req[2]), 0);
    $display("test timer done");
    for (int i = 0; i < 10; i++) ctx.word[i] = 32'ha000 + i;
    wr(32'h4, 32'h44);
    wr(32'hc, 32'hcc);
    @(posedge clk_sys);
    #1 ctx.load = 1'b1;
    @(posedge clk_sys);
    #1 ctx.load = 1'b0;
    foreach (PP[i]) rd(PP[i], 32'ha000 + i);
    rd(32'h4, 32'h44);
    rd(32'hc, 32'hcc);
    rd(32'h12, 32'h10);
    $display("test context load done");
    @(posedge clk_sys);
    #1 rst_n = 0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1;
    rd(32'h12, 32'h1f);
    rd(32'h38, 32'h0);
    check("map pin", 32'(mapping_enable), 0);
    $display("test second reset done");
    wrap_up;
  end
endmodule // processor_register_bank_tb_top
`default_nettype wire
